// ---- inc/slope_map.svh ----
// Constants of the frequency slope protection: timing, limit curve, register map.
// Assumes a 10 MHz system clock and slope samples in units of 0.01 Hz/s.
`ifndef SLOPE_MAP_SVH
`define SLOPE_MAP_SVH

// ==========================================================
// Clock and time base
`define CLK_PERIOD_NS 100
`define TICK_TIME_NS 1000000
`define TICK_CYCLES (`TICK_TIME_NS / `CLK_PERIOD_NS)
`define TICK_TIME_MS 1

// ==========================================================
// Stage timing, in milliseconds and in ticks
`define PICKUP_TIME_MS 80
`define PICKUP_TICKS (`PICKUP_TIME_MS / `TICK_TIME_MS)
`define START_TIME_MS 60
`define START_TICKS (`START_TIME_MS / `TICK_TIME_MS)
`define STABLE_TIME_MS 80
`define STABLE_TICKS (`STABLE_TIME_MS / `TICK_TIME_MS)

// ==========================================================
// Limit curve for sensitive thresholds (0.01 Hz/s units, ms)
`define LIMIT_KNEE_SLOPE 70
`define LIMIT_BASE_MS 140
`define LIMIT_STEP_MS 2
`define FULL_SCALE_PCT 100

// ==========================================================
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_EVT_EN 8'h04
`define OFS_STATUS 8'h08
`define OFS_MASK 8'h0C
`define OFS_STATE 8'h10
`define OFS_START_CNT 8'h14
`define OFS_TRIP_CNT 8'h18
`define OFS_FLT_MAX 8'h1C
`define OFS_ELAPSED_DELAY_PERCENT 8'h20
`define OFS_FREQ 8'h24
`define OFS_SLOPE 8'h28
`define OFS_GRP_BASE 8'h40
`define OFS_GRP_LAST 8'h7C

// ==========================================================
// Field positions and reset values
`define CTRL_EN_BIT 0
`define CTRL_EXT_BIT 3
`define CTRL_RST 32'h0000_0001
`define EVT_EN_RST 4'hF
`define THR_RST 16'h01F4
`define OP_MS_RST 16'h01F4
`define MIN_MS_RST 16'h01F4

`endif

// ---- inc/slope_pkg.sv ----
// Types shared by the slope protection files.
// Assumes slope_map.svh is included wherever offsets are needed.
package slope_pkg;

	// ==========================================================
	// Stage states
	typedef enum logic {ST_IDLE, ST_PICKED} prot_state_t;

	// One setting group: threshold, operate delay, minimum delay
	typedef struct packed {
		logic [15:0] thr;
		logic [15:0] op_ms;
		logic [15:0] min_ms;
	} setting_t;

	// One measurement sample
	typedef struct packed {
		logic [15:0] freq;
		logic [15:0] slope;
	} sample_t;

	// Events logged to the status register
	typedef struct packed {
		logic trip_off;
		logic trip_on;
		logic start_off;
		logic start_on;
	} event_t;

endpackage : slope_pkg

// ---- verilog/ms_tick.sv ----
// Millisecond time base: one-cycle tick every CYCLES clocks.
// Assumes a free-running system clock and synchronous reset.
`timescale 1ns/10ps

module ms_tick #(
	parameter int CYCLES = 10000
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// Tick out
	output logic tick_o
);

	// ==========================================================
	// Counter
	localparam int CW = $clog2(CYCLES);
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic tick_r, tick_nxt;

	// Next count; the tick marks the wrap
	always_comb begin
		cnt_nxt = cnt_r + 1'b1;
		tick_nxt = 1'b0;
		if (cnt_r == CW'(CYCLES - 1)) begin
			cnt_nxt = '0;
			tick_nxt = 1'b1;
		end
	end

	// Register the count
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick_o = tick_r;

	// ==========================================================
	// Checks
	property p_tick_single;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		tick_r |=> !tick_r;
	endproperty
	a_tick_single: assert property (p_tick_single) else $error("tick longer than one cycle"); // [R18]

endmodule : ms_tick

// ---- verilog/percent_div.sv ----
// Restoring divider used for the elapsed delay percentage.
// Assumes start only while not busy; a zero divisor yields all ones.
`timescale 1ns/10ps

module percent_div #(
	parameter int NUM_W = 24,
	parameter int DEN_W = 16
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// Request
	input wire logic start_i,
	input wire logic [NUM_W-1:0] num_i,
	input wire logic [DEN_W-1:0] den_i,
	// Answer
	output logic busy_o,
	output logic done_o,
	output logic [NUM_W-1:0] quo_o
);

	// ==========================================================
	// State
	localparam int CNT_W = $clog2(NUM_W + 1);
	logic [DEN_W:0] rem_r, rem_nxt;
	logic [NUM_W-1:0] quo_r, quo_nxt;
	logic [DEN_W-1:0] den_r, den_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic done_r, done_nxt;
	logic [DEN_W:0] rem_sh;

	// One quotient bit per cycle
	always_comb begin
		rem_nxt = rem_r;
		quo_nxt = quo_r;
		den_nxt = den_r;
		cnt_nxt = cnt_r;
		done_nxt = 1'b0;
		rem_sh = {rem_r[DEN_W-1:0], quo_r[NUM_W-1]};
		if (start_i && cnt_r == '0) begin
			rem_nxt = '0;
			quo_nxt = num_i;
			den_nxt = den_i;
			cnt_nxt = CNT_W'(NUM_W);
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - 1'b1;
			done_nxt = (cnt_r == CNT_W'(1));
			if (rem_sh >= {1'b0, den_r}) begin
				rem_nxt = rem_sh - {1'b0, den_r};
				quo_nxt = {quo_r[NUM_W-2:0], 1'b1};
			end else begin
				rem_nxt = rem_sh;
				quo_nxt = {quo_r[NUM_W-2:0], 1'b0};
			end
		end
	end

	// Register the divider state
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rem_r <= '0;
			quo_r <= '0;
			den_r <= '0;
			cnt_r <= '0;
			done_r <= 1'b0;
		end else begin
			rem_r <= rem_nxt;
			quo_r <= quo_nxt;
			den_r <= den_nxt;
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
		end
	end

	assign busy_o = (cnt_r != '0);
	assign done_o = done_r;
	assign quo_o = quo_r;

endmodule : percent_div

// ---- verilog/slope_protection.sv ----
// Frequency slope protection stage with register port and interrupt.
// Assumes one slope sample per millisecond tick, synchronous to ref_clk_i.
//
// How it works
// [R1] Pick up after 80 ms above threshold
// [R2] Start output 60 ms after pick-up
// [R3] Trip if average slope exceeds threshold
// [R4] Definite time needs minimum equal operate delay
// [R5] Release when stable 80 ms past delay
// [R6] Fluctuations keep pick-up; average from pick-up
// [R7] Minimum below operate delay gives inverse time
// [R8] Inverse time: threshold times delay over slope
// [R9] Operate time never below minimum delay
// [R10] Limit curve lengthens time below 0.7 Hz/s
// [R11] Four setting groups, selectable input or register
// [R12] Enables gate start and trip event logging
// [R13] Start and trip counters readable
// [R14] Record maximum slope per fault
// [R15] Record elapsed delay percent, full on trip
// [R16] Present frequency and slope readable
// [R17] Release clears outputs, accumulator, timers
// [R18] Timing in 1 ms ticks from clock
`timescale 1ns/10ps
`include "slope_map.svh"

module slope_protection #(
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Measurement
	input wire logic sample_valid_i,
	input wire logic [15:0] freq_i,
	input wire logic [15:0] slope_i,
	// Setting group select from digital or virtual inputs
	input wire logic [1:0] grp_sel_i,
	// Stage outputs
	output logic start_o,
	output logic trip_o,
	output logic irq_o
);

	// ==========================================================
	// Helpers
	// Magnitude of a signed slope, saturating the most negative code
	function automatic logic [15:0] mag16(input logic [15:0] v);
		logic [15:0] m;
		m = v[15] ? (~v + 16'h0001) : v;
		if (m[15]) begin
			m = 16'h7FFF;
		end
		return m;
	endfunction : mag16

	// Shortest operate time allowed for a sensitive threshold
	function automatic logic [15:0] limit_ms(input logic [15:0] thr);
		logic [15:0] d;
		d = 16'(`LIMIT_KNEE_SLOPE) - thr;
		if (thr >= 16'(`LIMIT_KNEE_SLOPE)) begin
			return 16'h0000;
		end
		return 16'(`LIMIT_BASE_MS) + 16'(d * 16'(`LIMIT_STEP_MS));
	endfunction : limit_ms

	// ==========================================================
	// Time base and divider
	logic tick;
	logic div_start, div_busy, div_done;
	logic [23:0] div_num, div_quo;
	slope_pkg::setting_t set; // Active setting group

	ms_tick #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_o(tick)
	);

	percent_div #(
		.NUM_W(24),
		.DEN_W(16)
	) u_div (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.start_i(div_start),
		.num_i(div_num),
		.den_i(set.op_ms),
		.busy_o(div_busy),
		.done_o(div_done),
		.quo_o(div_quo)
	);

	// ==========================================================
	// State declarations
	// Bus side
	logic [31:0] ctrl_r, ctrl_nxt; // Enable, manual group, source select
	logic [3:0] evt_en_r, evt_en_nxt; // Event logging enables
	logic [3:0] status_r, status_nxt; // Sticky events, write one to clear
	logic [3:0] mask_r, mask_nxt; // Interrupt mask
	logic [31:0] rdata_r, rdata_nxt;
	logic irq_r, irq_nxt;
	slope_pkg::setting_t grp_r [4]; // Four setting groups
	slope_pkg::setting_t grp_nxt [4];
	slope_pkg::sample_t smp_r, smp_nxt; // Latest measurement
	// Stage side
	slope_pkg::prot_state_t state_r, state_nxt;
	logic [15:0] above_r, above_nxt; // Ticks continuously above threshold
	logic [15:0] elapsed_r, elapsed_nxt; // Ticks since pick-up
	logic [15:0] stable_r, stable_nxt; // Ticks continuously below threshold
	logic [31:0] acc_r, acc_nxt; // Slope sum since pick-up
	logic start_r, start_nxt;
	logic trip_r, trip_nxt;
	logic [15:0] start_cnt_r, start_cnt_nxt;
	logic [15:0] trip_cnt_r, trip_cnt_nxt;
	logic [15:0] flt_run_r, flt_run_nxt; // Running maximum in this fault
	logic [15:0] flt_max_r, flt_max_nxt; // Maximum of the last fault
	logic [15:0] elapsed_delay_percent_r, elapsed_delay_percent_nxt; // Elapsed delay percent of last fault
	// Combinational terms
	slope_pkg::event_t evt;
	logic [1:0] act_grp;
	logic [15:0] abs_slope, slope_minimum_delay_eff, op_eff; // Minimum and operate delay in force
	logic [31:0] thr_op;
	logic above, trip_cond, release_cond, pend;

	// ==========================================================
	// Active settings and derived thresholds
	always_comb begin
		act_grp = ctrl_r[`CTRL_EXT_BIT] ? grp_sel_i : ctrl_r[2:1]; // [R11]
		set = grp_r[act_grp];
		abs_slope = mag16(smp_r.slope);
		above = abs_slope > set.thr;
		// Minimum delay, lengthened by the limit curve when sensitive
		slope_minimum_delay_eff = set.min_ms; // [R9]
		if (limit_ms(set.thr) > set.min_ms) begin
			slope_minimum_delay_eff = limit_ms(set.thr); // [R10]
		end
		// A lengthened minimum stretches the window too, else no trip could ever fall in it
		op_eff = set.op_ms;
		if (slope_minimum_delay_eff > set.op_ms) begin
			op_eff = slope_minimum_delay_eff; // [R10]
		end
		thr_op = set.thr * op_eff;
		// Average above threshold at time t is acc > thr*t; inverse time
		// trips once acc exceeds thr*op, never past op nor before slope_minimum_delay
		trip_cond = (acc_r > thr_op) && (elapsed_r >= slope_minimum_delay_eff) && (elapsed_r <= op_eff); // [R3] [R7] [R8]
		release_cond = (stable_r >= 16'(`STABLE_TICKS)) && (trip_r || elapsed_r > op_eff); // [R5]
		evt.start_on = start_nxt && !start_r && evt_en_r[0]; // [R12]
		evt.start_off = !start_nxt && start_r && evt_en_r[1]; // [R12]
		evt.trip_on = trip_nxt && !trip_r && evt_en_r[2]; // [R12]
		evt.trip_off = !trip_nxt && trip_r && evt_en_r[3]; // [R12]
		pend = |(status_r & mask_r);
	end

	// ==========================================================
	// Stage next state, advanced once per tick while enabled
	always_comb begin
		state_nxt = state_r;
		above_nxt = above_r;
		elapsed_nxt = elapsed_r;
		stable_nxt = stable_r;
		acc_nxt = acc_r;
		start_nxt = start_r;
		trip_nxt = trip_r;
		start_cnt_nxt = start_cnt_r;
		trip_cnt_nxt = trip_cnt_r;
		flt_run_nxt = flt_run_r;
		flt_max_nxt = flt_max_r;
		elapsed_delay_percent_nxt = elapsed_delay_percent_r;
		div_start = 1'b0;
		div_num = 24'(elapsed_r) * 24'(`FULL_SCALE_PCT);
		if (div_done) begin
			elapsed_delay_percent_nxt = (div_quo > 24'h00FFFF) ? 16'hFFFF : div_quo[15:0]; // [R15]
		end
		if (!ctrl_r[`CTRL_EN_BIT]) begin
			// Disabled stage drops state, timers, accumulator and outputs at once
			state_nxt = slope_pkg::ST_IDLE;
			above_nxt = '0;
			elapsed_nxt = '0;
			stable_nxt = '0;
			acc_nxt = '0;
			start_nxt = 1'b0;
			trip_nxt = 1'b0;
		end else if (tick) begin // [R18]
			case (state_r)
				slope_pkg::ST_IDLE: begin
					above_nxt = above ? above_r + 16'h0001 : 16'h0000;
					if (above && above_r + 16'h0001 >= 16'(`PICKUP_TICKS)) begin
						state_nxt = slope_pkg::ST_PICKED; // [R1]
						above_nxt = '0;
						elapsed_nxt = '0;
						stable_nxt = '0;
						acc_nxt = '0;
						flt_run_nxt = abs_slope;
					end
				end
				slope_pkg::ST_PICKED: begin
					// Short dips only advance the stability count
					elapsed_nxt = (elapsed_r == 16'hFFFF) ? elapsed_r : elapsed_r + 16'h0001; // [R6]
					acc_nxt = acc_r + 32'(abs_slope); // [R6]
					stable_nxt = above ? 16'h0000 : stable_r + 16'h0001;
					if (abs_slope > flt_run_r) begin
						flt_run_nxt = abs_slope; // [R14]
					end
					if (elapsed_r + 16'h0001 >= 16'(`START_TICKS) && !start_r) begin
						start_nxt = 1'b1; // [R2]
						start_cnt_nxt = start_cnt_r + 16'h0001; // [R13]
					end
					if (trip_cond && !trip_r) begin
						trip_nxt = 1'b1; // [R3]
						trip_cnt_nxt = trip_cnt_r + 16'h0001; // [R13]
					end
					if (release_cond) begin
						// Clear for the next pick-up and close the record
						state_nxt = slope_pkg::ST_IDLE; // [R17]
						elapsed_nxt = '0;
						stable_nxt = '0;
						acc_nxt = '0;
						start_nxt = 1'b0;
						trip_nxt = 1'b0;
						flt_max_nxt = flt_run_r; // [R14]
						if (trip_r) begin
							elapsed_delay_percent_nxt = 16'(`FULL_SCALE_PCT); // [R15]
						end else if (!div_busy) begin
							div_start = 1'b1; // [R15]
						end
					end
				end
				default: state_nxt = slope_pkg::ST_IDLE;
			endcase
		end
	end

	// Register the stage
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			state_r <= slope_pkg::ST_IDLE;
			above_r <= '0;
			elapsed_r <= '0;
			stable_r <= '0;
			acc_r <= '0;
			start_r <= 1'b0;
			trip_r <= 1'b0;
			start_cnt_r <= '0;
			trip_cnt_r <= '0;
			flt_run_r <= '0;
			flt_max_r <= '0;
			elapsed_delay_percent_r <= '0;
		end else begin
			state_r <= state_nxt;
			above_r <= above_nxt;
			elapsed_r <= elapsed_nxt;
			stable_r <= stable_nxt;
			acc_r <= acc_nxt;
			start_r <= start_nxt;
			trip_r <= trip_nxt;
			start_cnt_r <= start_cnt_nxt;
			trip_cnt_r <= trip_cnt_nxt;
			flt_run_r <= flt_run_nxt;
			flt_max_r <= flt_max_nxt;
			elapsed_delay_percent_r <= elapsed_delay_percent_nxt;
		end
	end

	// ==========================================================
	// Register port next state
	always_comb begin
		ctrl_nxt = ctrl_r;
		evt_en_nxt = evt_en_r;
		mask_nxt = mask_r;
		grp_nxt = grp_r;
		smp_nxt = smp_r;
		rdata_nxt = 32'h0000_0000;
		irq_nxt = pend;
		status_nxt = status_r;
		if (sample_valid_i) begin
			smp_nxt = {freq_i, slope_i};
		end
		if (reg_wr_i) begin
			if (reg_addr_i == `OFS_CTRL) begin
				ctrl_nxt = {28'h0000000, reg_wdata_i[3:0]};
			end else if (reg_addr_i == `OFS_EVT_EN) begin
				evt_en_nxt = reg_wdata_i[3:0];
			end else if (reg_addr_i == `OFS_STATUS) begin
				status_nxt = status_r & ~reg_wdata_i[3:0];
			end else if (reg_addr_i == `OFS_MASK) begin
				mask_nxt = reg_wdata_i[3:0];
			end else if (reg_addr_i >= `OFS_GRP_BASE && reg_addr_i <= `OFS_GRP_LAST) begin
				if (reg_addr_i[3:2] == 2'h0) begin
					grp_nxt[reg_addr_i[5:4]].thr = reg_wdata_i[15:0];
				end else if (reg_addr_i[3:2] == 2'h1) begin
					grp_nxt[reg_addr_i[5:4]].op_ms = reg_wdata_i[15:0];
				end else if (reg_addr_i[3:2] == 2'h2) begin
					grp_nxt[reg_addr_i[5:4]].min_ms = reg_wdata_i[15:0];
				end
			end
		end
		// New events win over a clear in the same cycle
		status_nxt = status_nxt | evt; // [R12]
		if (reg_rd_i) begin
			if (reg_addr_i == `OFS_CTRL) begin
				rdata_nxt = ctrl_r;
			end else if (reg_addr_i == `OFS_EVT_EN) begin
				rdata_nxt = {28'h0000000, evt_en_r};
			end else if (reg_addr_i == `OFS_STATUS) begin
				rdata_nxt = {28'h0000000, status_r};
			end else if (reg_addr_i == `OFS_MASK) begin
				rdata_nxt = {28'h0000000, mask_r};
			end else if (reg_addr_i == `OFS_STATE) begin
				rdata_nxt = {26'h0, act_grp, 1'b0, state_r == slope_pkg::ST_PICKED,
					trip_r, start_r};
			end else if (reg_addr_i == `OFS_START_CNT) begin
				rdata_nxt = {16'h0000, start_cnt_r}; // [R13]
			end else if (reg_addr_i == `OFS_TRIP_CNT) begin
				rdata_nxt = {16'h0000, trip_cnt_r}; // [R13]
			end else if (reg_addr_i == `OFS_FLT_MAX) begin
				rdata_nxt = {16'h0000, flt_max_r}; // [R14]
			end else if (reg_addr_i == `OFS_ELAPSED_DELAY_PERCENT) begin
				rdata_nxt = {16'h0000, elapsed_delay_percent_r}; // [R15]
			end else if (reg_addr_i == `OFS_FREQ) begin
				rdata_nxt = {16'h0000, smp_r.freq}; // [R16]
			end else if (reg_addr_i == `OFS_SLOPE) begin
				rdata_nxt = {16'h0000, smp_r.slope}; // [R16]
			end else if (reg_addr_i >= `OFS_GRP_BASE && reg_addr_i <= `OFS_GRP_LAST) begin
				if (reg_addr_i[3:2] == 2'h0) begin
					rdata_nxt = {16'h0000, grp_r[reg_addr_i[5:4]].thr};
				end else if (reg_addr_i[3:2] == 2'h1) begin
					rdata_nxt = {16'h0000, grp_r[reg_addr_i[5:4]].op_ms};
				end else if (reg_addr_i[3:2] == 2'h2) begin
					rdata_nxt = {16'h0000, grp_r[reg_addr_i[5:4]].min_ms};
				end
			end
		end
	end

	// Register the port side; settings reset to defaults
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			ctrl_r <= `CTRL_RST;
			evt_en_r <= `EVT_EN_RST;
			status_r <= 4'h0;
			mask_r <= 4'h0;
			rdata_r <= 32'h0000_0000;
			irq_r <= 1'b0;
			smp_r <= '0;
			for (int g = 0; g < 4; g++) begin
				grp_r[g] <= {`THR_RST, `OP_MS_RST, `MIN_MS_RST};
			end
		end else begin
			ctrl_r <= ctrl_nxt;
			evt_en_r <= evt_en_nxt;
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			rdata_r <= rdata_nxt;
			irq_r <= irq_nxt;
			smp_r <= smp_nxt;
			grp_r <= grp_nxt;
		end
	end

	assign reg_rdata_o = rdata_r;
	assign start_o = start_r;
	assign trip_o = trip_r;
	assign irq_o = irq_r;

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_release;
		(state_r == slope_pkg::ST_PICKED) ##1 (state_r == slope_pkg::ST_IDLE);
	endsequence

	property p_pickup;
		(state_r == slope_pkg::ST_IDLE) && tick && above && ctrl_r[0]
			&& (above_r == 16'(`PICKUP_TICKS - 1)) |=> (state_r == slope_pkg::ST_PICKED);
	endproperty
	a_pickup: assert property (p_pickup) else $error("no pick-up after full window"); // [R1]

	property p_start_delay;
		$rose(start_r) |-> (elapsed_r == 16'(`START_TICKS));
	endproperty
	a_start_delay: assert property (p_start_delay) else $error("start at wrong delay"); // [R2]

	property p_trip_cause;
		$rose(trip_r) |-> ($past(acc_r) > $past(thr_op));
	endproperty
	a_trip_cause: assert property (p_trip_cause) else $error("trip without average"); // [R3]

	property p_trip_min;
		$rose(trip_r) |-> ($past(elapsed_r) >= $past(slope_minimum_delay_eff));
	endproperty
	a_trip_min: assert property (p_trip_min) else $error("trip before minimum delay"); // [R9]

	property p_trip_max;
		$rose(trip_r) |-> ($past(elapsed_r) <= $past(op_eff));
	endproperty
	a_trip_max: assert property (p_trip_max) else $error("trip after operate delay"); // [R8]

	property p_release_clear;
		s_release |-> (!start_r && !trip_r && acc_r == 32'h0000_0000 && elapsed_r == 16'h0000);
	endproperty
	a_release_clear: assert property (p_release_clear) else $error("release left state"); // [R17]

	property p_hold;
		(state_r == slope_pkg::ST_PICKED) && ctrl_r[0] && !release_cond
			|=> (state_r == slope_pkg::ST_PICKED);
	endproperty
	a_hold: assert property (p_hold) else $error("dropped out without release"); // [R6]

	property p_start_count;
		$rose(start_r) |-> (start_cnt_r == $past(start_cnt_r) + 16'h0001);
	endproperty
	a_start_count: assert property (p_start_count) else $error("start count not advanced"); // [R13]

	property p_irq;
		pend |=> irq_r;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing"); // [R12]

endmodule : slope_protection

// ---- bench/slope_source.sv ----
// Measurement source model: one frequency and slope sample per time base tick.
// Assumes the bench sets the values; tick phase is free against the stage.
`timescale 1ns/10ps

module slope_source #(
	parameter int TC = 10
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// Values to send
	input wire logic [15:0] freq_set_i,
	input wire logic [15:0] slope_set_i,
	// Sample out
	output logic sample_valid_o,
	output logic [15:0] freq_o,
	output logic [15:0] slope_o
);
	// ==========================================================
	// Tick pacing
	int cnt_r; // Cycles since the last sample

	// One sample per tick, phase set by our own reset
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || cnt_r == TC - 1)
			cnt_r <= 0;
		else
			cnt_r <= cnt_r + 1;
	end

	// Pulse is one cycle long, never during reset
	assign sample_valid_o = (cnt_r == TC - 1) && !sys_rst_i;
	// Lines carry junk outside the pulse so a stale latch is caught
	assign freq_o = sample_valid_o ? freq_set_i : ~freq_set_i;
	assign slope_o = sample_valid_o ? slope_set_i : ~slope_set_i;
endmodule : slope_source

// ---- bench/slope_protection_tb.sv ----
// Self-checking bench of the slope protection stage.
// Assumes a short tick parameter; slope values in 0.01 Hz/s units.
`timescale 1ns/10ps
`include "slope_map.svh"

module slope_protection_tb;
	// ==========================================================
	// Signals
	localparam int TC = 10; // Short tick keeps the run small
	typedef struct packed {logic [7:0] a; logic [31:0] e;} row_t; // Address, expected
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1; // Held for six cycles
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic sample_valid_i;
	logic [15:0] freq_i;
	logic [15:0] slope_i;
	logic [15:0] slope_set = 16'h0000; // Slope the source sends
	logic [1:0] grp_sel_i = 2'b00;
	logic start_o;
	logic trip_o;
	logic irq_o;
	int bad_count = 0;
	int n_checks = 0;
	// Reset values, read-only and unmapped places after a write
	row_t rows [10] = '{'{8'h00, `CTRL_RST}, '{8'h04, {28'h0, `EVT_EN_RST}},
		'{8'h08, 32'h0}, '{8'h0C, 32'h0}, '{8'h14, 32'h0}, '{8'h30, 32'h0},
		'{8'h40, {16'h0, `THR_RST}}, '{8'h44, {16'h0, `OP_MS_RST}},
		'{8'h48, {16'h0, `MIN_MS_RST}}, '{8'h70, {16'h0, `THR_RST}}};

	always #50 ref_clk_i = ~ref_clk_i;

	// ==========================================================
	// Design and measurement source
	slope_protection #(.TICK_CYCLES(TC)) dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sample_valid_i(sample_valid_i),
		.freq_i(freq_i), .slope_i(slope_i), .grp_sel_i(grp_sel_i), .start_o(start_o),
		.trip_o(trip_o), .irq_o(irq_o));
	slope_source #(.TC(TC)) src (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.freq_set_i(16'h1388), .slope_set_i(slope_set), .sample_valid_o(sample_valid_i),
		.freq_o(freq_i), .slope_o(slope_i));

	// ==========================================================
	// Tasks
	// Compare and count; an unknown matches only an unknown
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	// Read strobe, data looked at in the following cycle only
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1 chk(reg_rdata_o, e);
	endtask : rd
	// Wait whole ticks, then let the edge settle
	task automatic ticks(input int n);
		repeat (n * TC) @(posedge ref_clk_i);
		#1;
	endtask : ticks
	// Interrupt level a little after a register write
	task automatic irq_is(input logic e);
		repeat (2) @(posedge ref_clk_i);
		#1 chk({31'h0, irq_o}, {31'h0, e});
	endtask : irq_is
	// Verdict and end of run
	task give_verdict;
		if (bad_count == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	// ==========================================================
	// Main sequence
	initial begin
		repeat (6) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		#1 chk({30'h0, start_o, trip_o}, 32'h0);
		wr(8'h14, 32'hFFFF);
		wr(8'h30, 32'hFFFF);
		foreach (rows[i]) rd(rows[i].a, rows[i].e);
		// Definite time: threshold 1.00, delays 200 ms, falling slope
		wr(8'h40, 32'h64);
		wr(8'h44, 32'hC8);
		wr(8'h48, 32'hC8);
		slope_set <= 16'hFED4;
		ticks(90);
		slope_set <= 16'h0000; // Short dip after pick-up must not release
		ticks(10);
		slope_set <= 16'hFED4;
		ticks(35);
		chk({31'h0, start_o}, 32'h0);
		ticks(10);
		chk({31'h0, start_o}, 32'h1);
		ticks(130);
		chk({31'h0, trip_o}, 32'h0);
		ticks(10);
		chk({31'h0, trip_o}, 32'h1);
		rd(8'h14, 32'h1);
		rd(8'h18, 32'h1);
		rd(8'h08, 32'h5);
		wr(8'h0C, 32'h4);
		irq_is(1'b1);
		wr(8'h08, 32'h4);
		irq_is(1'b0);
		// Stable slope releases the stage
		slope_set <= 16'h0000;
		ticks(90);
		chk({30'h0, start_o, trip_o}, 32'h0);
		repeat (30) @(posedge ref_clk_i);
		rd(8'h1C, 32'h12C);
		rd(8'h20, 32'h64);
		wr(8'h0C, 32'h8);
		irq_is(1'b1);
		wr(8'h08, 32'hF);
		irq_is(1'b0);
		// Inverse time: minimum 50 ms, average twice the threshold; trip-on not logged
		wr(8'h04, 32'hB);
		wr(8'h48, 32'h32);
		slope_set <= 16'h00C8;
		ticks(170);
		chk({31'h0, trip_o}, 32'h0);
		ticks(20);
		chk({31'h0, trip_o}, 32'h1);
		rd(8'h18, 32'h2);
		slope_set <= 16'h0000;
		ticks(90);
		rd(8'h08, 32'hB);
		rd(8'h20, 32'h64);
		rd(8'h1C, 32'hC8);
		// No trip: pick up, fall quiet, release just past a 100 ms delay
		wr(8'h44, 32'h64);
		wr(8'h48, 32'h64);
		slope_set <= 16'h012C;
		ticks(90);
		slope_set <= 16'h0000;
		ticks(100);
		chk({30'h0, start_o, trip_o}, 32'h0);
		rd(8'h14, 32'h3);
		rd(8'h18, 32'h2);
		rd(8'h20, 32'h65);
		rd(8'h1C, 32'h12C);
		// Manual group 1 with threshold 0.50: limit curve holds trip to 180 ms
		wr(8'h50, 32'h32);
		wr(8'h54, 32'h64);
		wr(8'h58, 32'h64);
		wr(8'h00, 32'h3);
		slope_set <= 16'hFED4;
		ticks(255);
		chk({31'h0, trip_o}, 32'h0);
		ticks(10);
		chk({31'h0, trip_o}, 32'h1);
		rd(8'h18, 32'h3);
		slope_set <= 16'h0000;
		ticks(90);
		// Group from the select input, measured values
		@(posedge ref_clk_i);
		grp_sel_i <= 2'b10;
		wr(8'h00, 32'h9);
		rd(8'h10, 32'h20);
		rd(8'h24, 32'h1388);
		rd(8'h28, 32'h0);
		give_verdict;
	end

	// Watchdog well past the expected run of some 1200 ticks
	initial begin
		#3000000;
		bad_count++;
		give_verdict;
	end
endmodule : slope_protection_tb
